// *** core/asr_bit_sync.sv ***
// two-flop level synchroniser
`timescale 1ns/10ps
module asr_bit_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta;

  // meta feeds only the second flop
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta <= RESET_VAL;
      q_out <= RESET_VAL;
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule // asr_bit_sync

// *** core/asr_pkg.sv ***
// shared constants and types for the serial register access block
package asr_pkg;

  // register select codes
  localparam logic [2:0] ASR_REG_COMM = 3'h0;
  localparam logic [2:0] ASR_REG_MODE = 3'h1;
  localparam logic [2:0] ASR_REG_FHI = 3'h2;
  localparam logic [2:0] ASR_REG_FLO = 3'h3;
  localparam logic [2:0] ASR_REG_TEST = 3'h4;
  localparam logic [2:0] ASR_REG_DATA = 3'h5;
  localparam logic [2:0] ASR_REG_ZCAL = 3'h6;
  localparam logic [2:0] ASR_REG_FCAL = 3'h7;

  // transfer lengths in serial clocks
  localparam logic [5:0] ASR_LEN_CMD = 6'h07;
  localparam logic [5:0] ASR_LEN_BYTE = 6'h08;
  localparam logic [5:0] ASR_LEN_SHORT = 6'h10;
  localparam logic [5:0] ASR_LEN_LONG = 6'h18;
  localparam logic [5:0] ASR_RESYNC_ONES = 6'h20;
  localparam logic [5:0] ASR_ONE = 6'h01;

  // command word fields, counted below the gate bit
  localparam int ASR_CMD_RS_LSB = 4;
  localparam int ASR_CMD_RW_BIT = 3;
  localparam int ASR_CMD_CH_LSB = 0;

  // mode and filter-high fields
  localparam int ASR_MODE_MD_LSB = 5;
  localparam int ASR_MODE_G_LSB = 2;
  localparam int ASR_FHI_UNI_BIT = 7;
  localparam int ASR_FHI_WL_BIT = 6;
  localparam int ASR_FHI_FS_LSB = 0;

  // reset values
  localparam logic [2:0] ASR_CH_RESET = 3'h4;
  localparam logic [7:0] ASR_MODE_RESET = 8'h00;
  localparam logic [7:0] ASR_FHI_RESET = 8'h00;
  localparam logic [7:0] ASR_FLO_RESET = 8'h00;
  localparam logic [7:0] ASR_TEST_RESET = 8'h00;
  localparam logic [23:0] ASR_ZCAL_RESET = 24'h000000;
  localparam logic [23:0] ASR_FCAL_RESET = 24'h000000;
  localparam logic [15:0] ASR_PAD16 = 16'h0000;

  // calibration pairs
  localparam int ASR_CAL_PAIRS = 3;
  localparam logic [1:0] ASR_PAIR_HI = 2'h2;

  typedef enum logic [1:0] {
    ASR_ST_IDLE = 2'b00,
    ASR_ST_CMD = 2'b01,
    ASR_ST_WR = 2'b10,
    ASR_ST_RD = 2'b11
  } asr_link_state_t;

  typedef struct packed {
    logic [2:0] channel;
    logic [7:0] mode;
    logic [7:0] fhi;
    logic [7:0] flo;
    logic [7:0] test;
    logic [23:0] zcal;
    logic [23:0] fcal;
  } asr_cfg_t;

endpackage

// *** core/asr_serial_regs.sv ***
// serial command-driven access to eight converter registers
`timescale 1ns/10ps
// Operation
// (R1) eight registers, all reachable through the serial port
// (R2) every transaction opens with a command register write
// (R3) after reset the port waits for a command write
// (R4) command picks direction and target of the next transfer
// (R5) host loads a register by command write, then data shift
// (R6) host reads a register by command write, then clocking out
// (R7) command holds channel; its readback shows conversion-ready status
// (R8) mode register sets calibration mode and gain
// (R9) filter-high sets word length, coding, top four filter bits
// (R10) filter-low holds the low eight filter bits
// (R11) test register exists, only used for device testing
// (R12) conversion results are read from the data register
// (R13) zero-scale register reaches selected channel's zero coefficient
// (R14) full-scale register reaches selected channel's full coefficient
// (R15) three-bit select; data 16/24, calibration 24, rest 8 bits
// (R16) leading ones on the gate bit hold; a zero loads seven bits
// (R17) 32 serial clocks with input high return port to waiting
// (R18) after the selected transfer the port returns to waiting
// (R19) filter word is filter-high top bits over filter-low bits
module asr_serial_regs (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic sclk_in,
  input wire logic din_in,
  output logic dout_out,
  output logic dout_en_out,
  input wire logic [23:0] conv_data_in,
  input wire logic conv_valid_in,
  output logic conv_ready_out,
  output logic conversion_ready_flag_n_out,
  output logic [2:0] channel_select_field_out,
  output logic [2:0] cal_mode_out,
  output logic [2:0] gain_code_out,
  output logic unipolar_out,
  output logic word_len_24_out,
  output logic [11:0] filter_word_out,
  output logic [7:0] test_reg_out,
  output logic [23:0] zero_coeff_out,
  output logic [23:0] full_coeff_out,
  output logic cfg_update_out
);

  localparam int CFG_W = $bits(asr_pkg::asr_cfg_t);

  // link domain state
  logic link_rst;
  asr_pkg::asr_link_state_t state;
  asr_pkg::asr_link_state_t next_state;
  logic [5:0] bit_cnt;
  logic [5:0] len_reg;
  logic [5:0] ones_cnt;
  logic [23:0] wr_shift;
  logic [23:0] rd_shift;
  logic [23:0] rd_value;
  logic [23:0] next_word;
  logic [2:0] register_select_field;
  logic [2:0] channel_select_field;
  logic [7:0] mode_reg;
  logic [7:0] fhi_reg;
  logic [7:0] flo_reg;
  logic [7:0] test_reg;
  logic [23:0] data_reg;
  logic [23:0] zcal_mem [asr_pkg::ASR_CAL_PAIRS];
  logic [23:0] fcal_mem [asr_pkg::ASR_CAL_PAIRS];
  logic conversion_ready_flag_n;
  logic cfg_dirty;
  logic [6:0] cmd_word;
  logic [2:0] cmd_rs;
  logic [2:0] cmd_ch;
  logic cmd_read;
  logic xfer_last;
  logic resync;
  logic cmd_done;
  logic wr_done;
  logic rd_done;
  logic res_valid;
  logic [23:0] res_data;
  logic [1:0] sel_pair;

  // core domain state
  logic core_ready_n;
  logic cfg_valid;
  logic [CFG_W-1:0] cfg_data;
  asr_pkg::asr_cfg_t core_cfg;

  asr_xfer_if #(.W(CFG_W)) cfg_if ();
  asr_xfer_if #(.W(24)) conv_if ();

  // channel to calibration pair: pairs 0/1 follow bit 0, bit 1 means pair 2
  function automatic logic [1:0] cal_pair(input logic [2:0] ch);
    cal_pair = ch[1] ? asr_pkg::ASR_PAIR_HI : {1'b0, ch[0]};
  endfunction

  // serial length of a register; data follows the word length bit
  function automatic logic [5:0] xfer_len(input logic [2:0] rs,
                                          input logic wl);
    if (rs == asr_pkg::ASR_REG_DATA)
      xfer_len = wl ? asr_pkg::ASR_LEN_LONG : asr_pkg::ASR_LEN_SHORT;
    else if (rs == asr_pkg::ASR_REG_ZCAL || rs == asr_pkg::ASR_REG_FCAL)
      xfer_len = asr_pkg::ASR_LEN_LONG;
    else
      xfer_len = asr_pkg::ASR_LEN_BYTE;
  endfunction

  // byte registers leave msb first from the top of the shifter
  function automatic logic [23:0] align8(input logic [7:0] b);
    align8 = {b, asr_pkg::ASR_PAD16};
  endfunction

  // link reset follows the core reset; needs serial edges to land
  asr_bit_sync #(.RESET_VAL(1'b1)) u_link_rst (
    .clk_in(sclk_in),
    .rst_in(1'b0),
    .d_in(reset_in),
    .q_out(link_rst)
  );

  // command decode
  assign next_word = {wr_shift[22:0], din_in};
  assign cmd_word = next_word[6:0];
  assign cmd_rs = cmd_word[asr_pkg::ASR_CMD_RS_LSB +: 3]; // see (R15)
  assign cmd_read = cmd_word[asr_pkg::ASR_CMD_RW_BIT]; // see (R4)
  assign cmd_ch = cmd_word[asr_pkg::ASR_CMD_CH_LSB +: 3];
  assign xfer_last = (bit_cnt == len_reg - asr_pkg::ASR_ONE);
  assign resync = din_in &&
    (ones_cnt == asr_pkg::ASR_RESYNC_ONES - asr_pkg::ASR_ONE); // see (R17)
  assign cmd_done = (state == asr_pkg::ASR_ST_CMD) && xfer_last && !resync;
  assign wr_done = (state == asr_pkg::ASR_ST_WR) && xfer_last && !resync;
  assign rd_done = (state == asr_pkg::ASR_ST_RD) && xfer_last && !resync;
  assign sel_pair = cal_pair(channel_select_field);

  always_comb
  begin
    next_state = state;
    case (state)
      asr_pkg::ASR_ST_IDLE:
      begin
        // a one on the gate bit keeps us parked here
        if (!din_in)
          next_state = asr_pkg::ASR_ST_CMD; // see (R16) (R2)
      end
      asr_pkg::ASR_ST_CMD:
      begin
        if (cmd_done)
        begin
          if (cmd_read)
            next_state = asr_pkg::ASR_ST_RD; // see (R6)
          else if (cmd_rs == asr_pkg::ASR_REG_COMM)
            next_state = asr_pkg::ASR_ST_IDLE;
          else
            next_state = asr_pkg::ASR_ST_WR; // see (R5)
        end
      end
      asr_pkg::ASR_ST_WR:
      begin
        if (wr_done)
          next_state = asr_pkg::ASR_ST_IDLE; // see (R18)
      end
      asr_pkg::ASR_ST_RD:
      begin
        if (rd_done)
          next_state = asr_pkg::ASR_ST_IDLE; // see (R18)
      end
      default:
      begin
        next_state = asr_pkg::ASR_ST_IDLE;
      end
    endcase
    if (resync)
      next_state = asr_pkg::ASR_ST_IDLE; // see (R17)
  end

  // sequencer, counters and input shifter
  always_ff @(posedge sclk_in)
  begin
    if (link_rst)
    begin
      state <= asr_pkg::ASR_ST_IDLE; // see (R3)
      bit_cnt <= '0;
      len_reg <= asr_pkg::ASR_LEN_CMD;
      wr_shift <= '0;
    end
    else
    begin
      state <= next_state;
      wr_shift <= next_word;
      if (next_state != state || resync)
        bit_cnt <= '0;
      else if (state != asr_pkg::ASR_ST_IDLE)
        bit_cnt <= bit_cnt + asr_pkg::ASR_ONE;
      if (state == asr_pkg::ASR_ST_IDLE)
        len_reg <= asr_pkg::ASR_LEN_CMD; // see (R16)
      else if (cmd_done)
        len_reg <= xfer_len(cmd_rs, fhi_reg[asr_pkg::ASR_FHI_WL_BIT]);
    end
  end

  // run of consecutive ones on the data input
  always_ff @(posedge sclk_in)
  begin
    if (link_rst || !din_in || resync)
      ones_cnt <= '0;
    else
      ones_cnt <= ones_cnt + asr_pkg::ASR_ONE;
  end

  // command register contents
  always_ff @(posedge sclk_in)
  begin
    if (link_rst)
    begin
      register_select_field <= asr_pkg::ASR_REG_COMM;
      channel_select_field <= asr_pkg::ASR_CH_RESET;
    end
    else if (cmd_done)
    begin
      register_select_field <= cmd_rs; // see (R4)
      channel_select_field <= cmd_ch; // see (R7)
    end
  end

  // byte registers; the data register ignores writes
  always_ff @(posedge sclk_in)
  begin
    if (link_rst)
    begin
      mode_reg <= asr_pkg::ASR_MODE_RESET;
      fhi_reg <= asr_pkg::ASR_FHI_RESET;
      flo_reg <= asr_pkg::ASR_FLO_RESET;
      test_reg <= asr_pkg::ASR_TEST_RESET;
    end
    else if (wr_done)
    begin
      case (register_select_field)
        asr_pkg::ASR_REG_MODE: mode_reg <= next_word[7:0]; // see (R8)
        asr_pkg::ASR_REG_FHI: fhi_reg <= next_word[7:0]; // see (R9)
        asr_pkg::ASR_REG_FLO: flo_reg <= next_word[7:0]; // see (R10)
        asr_pkg::ASR_REG_TEST: test_reg <= next_word[7:0]; // see (R11)
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // calibration coefficients, one pair per channel group
  always_ff @(posedge sclk_in)
  begin
    if (link_rst)
    begin
      for (int i = 0; i < asr_pkg::ASR_CAL_PAIRS; i++)
      begin
        zcal_mem[i] <= asr_pkg::ASR_ZCAL_RESET;
        fcal_mem[i] <= asr_pkg::ASR_FCAL_RESET;
      end
    end
    else if (wr_done)
    begin
      if (register_select_field == asr_pkg::ASR_REG_ZCAL)
        zcal_mem[sel_pair] <= next_word; // see (R13)
      if (register_select_field == asr_pkg::ASR_REG_FCAL)
        fcal_mem[sel_pair] <= next_word; // see (R14)
    end
  end

  // latest result and its ready flag; a new result beats the clear
  always_ff @(posedge sclk_in)
  begin
    if (link_rst)
    begin
      data_reg <= '0;
      conversion_ready_flag_n <= 1'b1;
    end
    else if (res_valid)
    begin
      data_reg <= res_data; // see (R12)
      conversion_ready_flag_n <= 1'b0;
    end
    else if (rd_done && register_select_field == asr_pkg::ASR_REG_DATA)
      conversion_ready_flag_n <= 1'b1;
  end

  // readback word, left aligned for msb-first shifting
  always_comb
  begin
    rd_value = '0;
    case (cmd_rs)
      asr_pkg::ASR_REG_COMM:
        rd_value = align8({conversion_ready_flag_n, cmd_word}); // see (R7)
      asr_pkg::ASR_REG_MODE: rd_value = align8(mode_reg);
      asr_pkg::ASR_REG_FHI: rd_value = align8(fhi_reg);
      asr_pkg::ASR_REG_FLO: rd_value = align8(flo_reg);
      asr_pkg::ASR_REG_TEST: rd_value = align8(test_reg);
      asr_pkg::ASR_REG_DATA: rd_value = data_reg; // see (R12) (R15)
      asr_pkg::ASR_REG_ZCAL: rd_value = zcal_mem[cal_pair(cmd_ch)]; // see (R13)
      asr_pkg::ASR_REG_FCAL: rd_value = fcal_mem[cal_pair(cmd_ch)]; // see (R14)
      default: rd_value = '0;
    endcase
  end

  // output shifter; first bit shows at the edge that ends the command
  always_ff @(posedge sclk_in)
  begin
    if (link_rst)
      rd_shift <= '0;
    else if (cmd_done && cmd_read)
      rd_shift <= rd_value; // see (R1) (R6)
    else if (state == asr_pkg::ASR_ST_RD)
      rd_shift <= {rd_shift[22:0], 1'b0};
  end

  assign dout_out = rd_shift[23];
  assign dout_en_out = (state == asr_pkg::ASR_ST_RD);

  // any change of configuration is pushed to the core side
  always_ff @(posedge sclk_in)
  begin
    if (link_rst)
      cfg_dirty <= 1'b1;
    else if (cmd_done || wr_done)
      cfg_dirty <= 1'b1;
    else if (cfg_if.valid && cfg_if.ready)
      cfg_dirty <= 1'b0;
  end

  assign cfg_if.valid = cfg_dirty;
  assign cfg_if.data = {channel_select_field, mode_reg, fhi_reg, flo_reg,
                        test_reg, zcal_mem[sel_pair], fcal_mem[sel_pair]};

  asr_word_sync #(.W(CFG_W)) u_cfg_sync (
    .src_clk_in(sclk_in),
    .src_rst_in(link_rst),
    .src_en_in(1'b1),
    .src(cfg_if.sink),
    .dst_clk_in(core_clk_in),
    .dst_rst_in(reset_in),
    .dst_en_in(clk_en_in),
    .dst_valid_out(cfg_valid),
    .dst_data_out(cfg_data)
  );

  // results travel the other way; a busy crossing stalls the source
  assign conv_if.valid = conv_valid_in;
  assign conv_if.data = conv_data_in;
  assign conv_ready_out = conv_if.ready;

  asr_word_sync #(.W(24)) u_conv_sync (
    .src_clk_in(core_clk_in),
    .src_rst_in(reset_in),
    .src_en_in(clk_en_in),
    .src(conv_if.sink),
    .dst_clk_in(sclk_in),
    .dst_rst_in(link_rst),
    .dst_en_in(1'b1),
    .dst_valid_out(res_valid),
    .dst_data_out(res_data)
  );

  asr_bit_sync #(.RESET_VAL(1'b1)) u_rdy_sync (
    .clk_in(core_clk_in),
    .rst_in(reset_in),
    .d_in(conversion_ready_flag_n),
    .q_out(core_ready_n)
  );

  // core-side copy of the configuration
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      core_cfg.channel <= asr_pkg::ASR_CH_RESET;
      core_cfg.mode <= asr_pkg::ASR_MODE_RESET;
      core_cfg.fhi <= asr_pkg::ASR_FHI_RESET;
      core_cfg.flo <= asr_pkg::ASR_FLO_RESET;
      core_cfg.test <= asr_pkg::ASR_TEST_RESET;
      core_cfg.zcal <= asr_pkg::ASR_ZCAL_RESET;
      core_cfg.fcal <= asr_pkg::ASR_FCAL_RESET;
      cfg_update_out <= 1'b0;
      conversion_ready_flag_n_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      cfg_update_out <= cfg_valid;
      conversion_ready_flag_n_out <= core_ready_n;
      if (cfg_valid)
        core_cfg <= asr_pkg::asr_cfg_t'(cfg_data);
    end
  end

  assign channel_select_field_out = core_cfg.channel;
  assign cal_mode_out = core_cfg.mode[asr_pkg::ASR_MODE_MD_LSB +: 3]; // see (R8)
  assign gain_code_out = core_cfg.mode[asr_pkg::ASR_MODE_G_LSB +: 3];
  assign unipolar_out = core_cfg.fhi[asr_pkg::ASR_FHI_UNI_BIT]; // see (R9)
  assign word_len_24_out = core_cfg.fhi[asr_pkg::ASR_FHI_WL_BIT];
  assign filter_word_out = {core_cfg.fhi[asr_pkg::ASR_FHI_FS_LSB +: 4],
                            core_cfg.flo}; // see (R19)
  assign test_reg_out = core_cfg.test; // see (R11)
  assign zero_coeff_out = core_cfg.zcal;
  assign full_coeff_out = core_cfg.fcal;

endmodule // asr_serial_regs

// *** core/asr_word_sync.sv ***
// toggle handshake carrying one word between two clock domains
`timescale 1ns/10ps
module asr_word_sync #(
  parameter int W = 8
) (
  input wire logic src_clk_in,
  input wire logic src_rst_in,
  input wire logic src_en_in,
  asr_xfer_if.sink src,
  input wire logic dst_clk_in,
  input wire logic dst_rst_in,
  input wire logic dst_en_in,
  output logic dst_valid_out,
  output logic [W-1:0] dst_data_out
);
  logic req_tgl;
  logic ack_tgl;
  logic ack_seen;
  logic req_seen;
  logic [W-1:0] hold;

  asr_bit_sync u_ack_sync (
    .clk_in(src_clk_in),
    .rst_in(src_rst_in),
    .d_in(ack_tgl),
    .q_out(ack_seen)
  );

  asr_bit_sync u_req_sync (
    .clk_in(dst_clk_in),
    .rst_in(dst_rst_in),
    .d_in(req_tgl),
    .q_out(req_seen)
  );

  // hold stays still until the far side has answered
  assign src.ready = (req_tgl == ack_seen);

  always_ff @(posedge src_clk_in)
  begin
    if (src_rst_in)
    begin
      req_tgl <= 1'b0;
      hold <= '0;
    end
    else if (src_en_in && src.valid && src.ready)
    begin
      hold <= src.data;
      req_tgl <= ~req_tgl;
    end
  end

  always_ff @(posedge dst_clk_in)
  begin
    if (dst_rst_in)
    begin
      ack_tgl <= 1'b0;
      dst_valid_out <= 1'b0;
      dst_data_out <= '0;
    end
    else if (dst_en_in)
    begin
      dst_valid_out <= (req_seen != ack_tgl);
      if (req_seen != ack_tgl)
      begin
        dst_data_out <= hold;
        ack_tgl <= req_seen;
      end
    end
  end
endmodule // asr_word_sync

// *** core/asr_xfer_if.sv ***
// valid/ready word carrier between the block's modules
`timescale 1ns/10ps
interface asr_xfer_if #(
  parameter int W = 8
) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// *** tb/asr_host_model.sv ***
// serial host: link clock, data in, capture of read data
`timescale 1ns/10ps
module asr_host_model (
  output logic sclk_out,
  output logic din_out,
  input wire logic dout_in,
  output logic done_out,
  output logic [23:0] word_out
);
  logic [24:0] cap;
  initial
  begin
    sclk_out = 1'b0;
    din_out = 1'b1;
    done_out = 1'b0;
    word_out = 24'h000000;
  end
  // clock stands low between frames; din idles high, ignored at the gate
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      din_out = v[i];
      #40 sclk_out = 1'b1;
      #40 sclk_out = 1'b0;
      cap = {cap[23:0], dout_in};
    end
    din_out = 1'b1;
  endtask
  task automatic idle(input int n);
    repeat (n) shift(32'hFFFFFFFF, 1);
  endtask
  // command first, then the data bits of the selected register
  task automatic wr(input logic [7:0] c, input logic [23:0] d, input int n);
    shift(({24'h0, c} << n) | (d & ((32'h1 << n) - 1)), 8 + n);
  endtask
  // last sample is past the transfer, hence the drop of bit 0
  task automatic rd(input logic [7:0] c, input int n);
    shift(({24'h0, c} << n) | ((32'h1 << n) - 1), 8 + n);
    word_out = cap[24:1] & ((24'h1 << n) - 24'h1);
    done_out = 1'b1;
    #10 done_out = 1'b0;
  endtask
endmodule // asr_host_model

// *** tb/asr_serial_regs_assertions.sv ***
// port checks for the serial register access block
`timescale 1ns/10ps
module asr_serial_regs_assertions (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic sclk_in,
  input wire logic din_in,
  input wire logic dout_en_out,
  input wire logic conv_valid_in,
  input wire logic conv_ready_out,
  input wire logic conversion_ready_flag_n_out,
  input wire logic [2:0] channel_select_field_out,
  input wire logic [2:0] cal_mode_out,
  input wire logic [2:0] gain_code_out,
  input wire logic [11:0] filter_word_out,
  input wire logic [7:0] test_reg_out,
  input wire logic [23:0] zero_coeff_out,
  input wire logic [23:0] full_coeff_out,
  input wire logic cfg_update_out
);
  // saturating run of ones; counter, since a 32 repeat is too costly
  logic [5:0] ones_cnt;
  always_ff @(posedge sclk_in)
  begin
    if (reset_in || !din_in)
      ones_cnt <= 6'h00;
    else if (ones_cnt != 6'h20)
      ones_cnt <= ones_cnt + 6'h01;
  end
  a_reset_chan: assert property (@(posedge core_clk_in)
    disable iff (reset_in) $fell(reset_in) |->
    channel_select_field_out == 3'h4 && conversion_ready_flag_n_out)
    else $error("channel or flag not at reset value");
  a_reset_cfg: assert property (@(posedge core_clk_in)
    disable iff (reset_in) $fell(reset_in) |-> conv_ready_out &&
    {cal_mode_out, gain_code_out, filter_word_out, test_reg_out,
    zero_coeff_out, full_coeff_out} == 74'h0)
    else $error("settings not at reset value");
  a_take_ready: assert property (@(posedge core_clk_in)
    disable iff (reset_in) clk_en_in && conv_valid_in && conv_ready_out
    |=> !conv_ready_out)
    else $error("ready stayed high after a take");
  a_cfg_pulse: assert property (@(posedge core_clk_in)
    disable iff (reset_in) cfg_update_out |=> !cfg_update_out)
    else $error("update pulse longer than one cycle");
  a_copy_pulse: assert property (@(posedge core_clk_in)
    disable iff (reset_in)
    !$stable({channel_select_field_out, cal_mode_out, gain_code_out,
    filter_word_out, test_reg_out, zero_coeff_out, full_coeff_out})
    |-> cfg_update_out || $past(cfg_update_out))
    else $error("settings changed without update pulse");
  a_read_min: assert property (@(posedge sclk_in)
    disable iff (reset_in) $rose(dout_en_out) |-> dout_en_out [*8])
    else $error("read shorter than eight bits");
  a_read_ends: assert property (@(posedge sclk_in)
    disable iff (reset_in) $rose(dout_en_out) |-> ##[8:24] !dout_en_out)
    else $error("read did not end");
  a_gate_hold: assert property (@(posedge sclk_in)
    disable iff (reset_in) (!dout_en_out && din_in) [*8] |=> !dout_en_out)
    else $error("ones started a transfer");
  a_resync_idle: assert property (@(posedge sclk_in)
    disable iff (reset_in) ones_cnt == 6'h20 |-> !dout_en_out)
    else $error("port busy after run of ones");
  c_read: cover property (@(posedge sclk_in) $rose(dout_en_out));
  c_take: cover property (@(posedge core_clk_in) $fell(conv_ready_out));
  c_flag: cover property (@(posedge core_clk_in)
    $fell(conversion_ready_flag_n_out));
  c_ones: cover property (@(posedge sclk_in) ones_cnt == 6'h20);
endmodule // asr_serial_regs_assertions

bind asr_serial_regs asr_serial_regs_assertions asr_serial_regs_assertions_i (
  .core_clk_in, .reset_in, .clk_en_in, .sclk_in, .din_in, .dout_en_out,
  .conv_valid_in, .conv_ready_out, .conversion_ready_flag_n_out,
  .channel_select_field_out, .cal_mode_out, .gain_code_out,
  .filter_word_out, .test_reg_out, .zero_coeff_out, .full_coeff_out,
  .cfg_update_out);

// *** tb/tb_asr_serial_regs.sv ***
// self-checking bench for the serial register access block
`timescale 1ns/10ps
module tb_asr_serial_regs;
  logic core_clk_in, reset_in, clk_en_in, conv_valid_in;
  logic sclk, din, done, dout, dout_en, rdy, flag_n, cfg, uni, wl;
  logic [2:0] chan, cal_mode, gain;
  logic [11:0] filt;
  logic [7:0] test_reg, seed;
  logic [7:0] mv [0:4];
  logic [23:0] conv_data_in, v, zc, fc, word;
  logic [23:0] zv [3];
  logic [23:0] fv [3];
  logic [23:0] expq [$];
  int mismatches, check_count, cyc, p;
  asr_serial_regs asr_serial_regs_i (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .clk_en_in(clk_en_in), .sclk_in(sclk),
    .din_in(din), .dout_out(dout), .dout_en_out(dout_en),
    .conv_data_in(conv_data_in), .conv_valid_in(conv_valid_in),
    .conv_ready_out(rdy), .conversion_ready_flag_n_out(flag_n),
    .channel_select_field_out(chan), .cal_mode_out(cal_mode),
    .gain_code_out(gain), .unipolar_out(uni), .word_len_24_out(wl),
    .filter_word_out(filt), .test_reg_out(test_reg), .zero_coeff_out(zc),
    .full_coeff_out(fc), .cfg_update_out(cfg));
  asr_host_model asr_host_model_i (.sclk_out(sclk), .din_out(din),
    .dout_in(dout), .done_out(done), .word_out(word));
  function automatic logic [7:0] cmd(input logic [2:0] rs, input logic rw,
    input logic [2:0] ch);
    return {1'b0, rs, rw, ch};
  endfunction
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic rnd(output logic [23:0] r);
    r = 24'h000000;
    repeat (3)
    begin
      seed = lfsr(seed);
      r = {r[15:0], seed};
    end
  endtask
  task automatic check(input string what, input logic [23:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // copies cross on both clocks, so the link clock must run meanwhile
  task automatic settle();
    asr_host_model_i.idle(8);
    repeat (10) @(posedge core_clk_in);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  always @(posedge done) check("read", word, expq.pop_front());
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    reset_in = 1'b1;
    clk_en_in = 1'b1;
    conv_valid_in = 1'b0;
    conv_data_in = 24'h000000;
    seed = 8'h56;
    // link side resets only through sclk edges seen during reset
    asr_host_model_i.idle(4);
    repeat (6) @(posedge core_clk_in);
    reset_in <= 1'b0;
    settle();
    check("chan", chan, asr_pkg::ASR_CH_RESET);
    check("flag rdy", {flag_n, rdy}, 24'h3);
    check("cfg", {cal_mode, gain, filt, test_reg}, 24'h0);
    check("cal", zc | fc, 24'h0);
    mv[0] = 8'h8C;
    for (int r = 1; r <= 4; r++)
    begin
      rnd(v);
      mv[r] = v[7:0] & ((r == 2) ? 8'hBF : 8'hFF);
      asr_host_model_i.wr(cmd(r, 1'b0, 3'h4), mv[r], 8);
    end
    for (int r = 0; r <= 4; r++)
    begin
      expq.push_back(mv[r]);
      asr_host_model_i.rd(cmd(r, 1'b1, 3'h4), 8);
    end
    settle();
    check("mode", {cal_mode, gain}, mv[1][7:2]);
    check("fhi", {uni, wl}, mv[2][7:6]);
    check("filt", filt, {mv[2][3:0], mv[3]});
    check("test", test_reg, mv[4]);
    $display("test regs done");
    for (int c = 0; c < 3; c++)
    begin
      rnd(zv[c]);
      rnd(fv[c]);
      asr_host_model_i.wr(cmd(6, 1'b0, c), zv[c], 24);
      asr_host_model_i.wr(cmd(7, 1'b0, c), fv[c], 24);
    end
    for (int c = 0; c < 8; c++)
    begin
      p = c[1] ? 2 : c[0];
      expq.push_back(zv[p]);
      asr_host_model_i.rd(cmd(6, 1'b1, c), 24);
      expq.push_back(fv[p]);
      asr_host_model_i.rd(cmd(7, 1'b1, c), 24);
    end
    settle();
    check("zero", zc, zv[2]);
    check("full", fc, fv[2]);
    $display("test cal done");
    for (int w = 0; w < 2; w++)
    begin
      asr_host_model_i.wr(cmd(2, 1'b0, 3'h3), {1'b0, w[0], 6'h0}, 8);
      rnd(v);
      @(posedge core_clk_in);
      conv_data_in <= v;
      conv_valid_in <= 1'b1;
      @(posedge core_clk_in);
      conv_valid_in <= 1'b0;
      #1 check("taken", rdy, 24'h0);
      settle();
      check("flag set", flag_n, 24'h0);
      expq.push_back(24'h0B);
      asr_host_model_i.rd(cmd(0, 1'b1, 3'h3), 8);
      asr_host_model_i.wr(cmd(5, 1'b0, 3'h3), ~v, 16 + 8 * w);
      expq.push_back(w ? v : v[23:8]);
      asr_host_model_i.rd(cmd(5, 1'b1, 3'h3), 16 + 8 * w);
      settle();
      check("flag clear", flag_n, 24'h1);
    end
    $display("test data done");
    asr_host_model_i.shift(32'h0, 1);
    asr_host_model_i.idle(40);
    settle();
    check("resync chan", chan, 24'h7);
    // command-only write: channel moves, port stays idle
    asr_host_model_i.wr(cmd(0, 1'b0, 3'h5), 24'h0, 0);
    settle();
    check("cmd only chan", chan, 24'h5);
    expq.push_back(mv[1]);
    asr_host_model_i.rd(cmd(1, 1'b1, 3'h4), 8);
    $display("test resync done");
    stop_test();
  end
endmodule // tb_asr_serial_regs
